// *** core/mfctl_host.v ***
// host controller for an asynchronous multi-bank parallel nor flash
// assumes apb software side, flash pins reach this block unsynchronised
// Device rules this block follows or relies on
// R1 - reads to idle banks proceed during busy
// R2 - at most two banks active together
// R3 - secured sector accessed like normal sector
// R4 - lock indicator bit six reported
// R5 - commands issued as plain write cycles
// R6 - progress seen via done pin, poll, toggles
// R7 - device returns to read by itself
// R8 - erasing a sector spares the others
// R9 - device ignores writes at low supply
// R10 - protected sectors refuse program and erase
// R11 - erase suspend lets other sectors work
// R12 - secured sector read needs entry/exit sequence
// R13 - stable address lets device auto sleep
// R14 - host may force standby
// R15 - top data pin is low address in byte mode
// R16 - reset input is active low
// R17 - done pin low while operation runs
// R18 - chip select low for every access
// R19 - fixed sector addresses, top or bottom boot
// R20 - byte mode floats data pins fourteen to eight
// R21 - protect pin low guards outer boot sectors
// R22 - hardware reset returns device to read
// R23 - check busy before new program or erase
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "mfctl_defines.vh"

module mfctl_host #(
	parameter AW = 21
)(
	input wire pclk,
	input wire presetn,
	input wire pclken,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output reg [AW-1:0] flash_addr,
	output reg chip_sel_n,
	output reg out_en_n,
	output reg wr_en_n,
	output reg rst_n_pin,
	output reg width_sel_n,
	output reg protect_boost_pin,
	input wire [14:0] dq_in,
	output reg [14:0] dq_out,
	output reg [14:0] dq_oe,
	input wire top_data_or_low_addr_in,
	output reg top_data_or_low_addr_out,
	output reg top_data_or_low_addr_oe,
	input wire done_flag_n
);

	// ----------------------------------------------------------------
	// states and sizes
	// ----------------------------------------------------------------
	localparam S_IDLE = 3'h0;
	localparam S_RD = 3'h1;
	localparam S_WR = 3'h2;
	localparam S_REC = 3'h3;
	localparam S_RST = 3'h4;
	localparam integer ACC_N = `MFC_ACC_CYC;
	localparam integer WP_N = `MFC_WP_CYC;
	localparam integer RST_N = `MFC_RST_CYC;

	reg [2:0] state_reg;
	reg [7:0] cnt_reg;
	reg [AW:0] addr_reg;
	reg [15:0] wdata_reg;
	reg [15:0] rdata_reg;
	reg [3:0] ctrl_reg;
	reg [1:0] op_reg;
	reg toggling_reg;
	reg op_done_reg;
	reg [2:0] done_sync_reg;
	reg done_n_reg;
	reg [15:0] dq_s1_reg;
	reg [15:0] dq_s2_reg;
	reg [15:0] dq_s3_reg;

	wire wr_acc = psel & penable & pwrite & pclken;
	wire busy = (state_reg != S_IDLE);
	wire word_mode = ctrl_reg[`MFC_CTRL_WORD];
	wire [15:0] dq_now = dq_s3_reg;

	assign pready = 1'b1;
	assign pslverr = 1'b0;

	function in_map;
		input [11:0] a;
		begin
			in_map = (a == `MFC_ADDR_REG) || (a == `MFC_WDATA_REG) ||
				(a == `MFC_CMD_REG) || (a == `MFC_STATUS_REG) ||
				(a == `MFC_RDATA_REG) || (a == `MFC_CTRL_REG);
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// a done pin change is trusted only when stages two and three agree; the data pins pass the three stages unfiltered
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_sync_reg <= 3'h7;
			done_n_reg <= 1'b1;
			dq_s1_reg <= 16'h0000;
			dq_s2_reg <= 16'h0000;
			dq_s3_reg <= 16'h0000;
		end
		else if (pclken)
		begin
			done_sync_reg <= {done_sync_reg[1:0], done_flag_n};
			if (done_sync_reg[1] == done_sync_reg[2])
				done_n_reg <= done_sync_reg[2];
			dq_s1_reg <= {top_data_or_low_addr_in, dq_in};
			dq_s2_reg <= dq_s1_reg;
			dq_s3_reg <= dq_s2_reg;
		end
	end

	// ----------------------------------------------------------------
	// apb read mux
	// ----------------------------------------------------------------
	always @*
	begin
		prdata = 32'h00000000;
		if (psel && !pwrite && in_map(paddr))
		begin
			case (paddr)
				`MFC_ADDR_REG: prdata = {{(31-AW){1'b0}}, addr_reg};
				`MFC_WDATA_REG: prdata = {16'h0000, wdata_reg};
				`MFC_RDATA_REG: prdata = {16'h0000, rdata_reg};
				`MFC_CTRL_REG: prdata = {28'h0000000, ctrl_reg};
				// progress bits mirror the last captured data [R6] [R4]
				`MFC_STATUS_REG: prdata = {24'h000000, toggling_reg, op_done_reg,
					rdata_reg[6], rdata_reg[2], rdata_reg[6], rdata_reg[7],
					done_n_reg, busy | ~done_n_reg};
				default: prdata = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// flash cycle sequencer
	// ----------------------------------------------------------------
	// the device needs no idle read to leave program mode, so the
	// sequencer never issues one after an operation [R7]
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= S_IDLE;
			cnt_reg <= 8'h00;
			addr_reg <= {(AW+1){1'b0}};
			wdata_reg <= 16'h0000;
			rdata_reg <= 16'h0000;
			ctrl_reg <= `MFC_CTRL_RESET_VAL;
			op_reg <= `MFC_CMD_READ;
			toggling_reg <= 1'b0;
			op_done_reg <= 1'b0;
		end
		else if (pclken)
		begin
			if (wr_acc && paddr == `MFC_CTRL_REG)
				ctrl_reg <= pwdata[3:0];
			if (wr_acc && !busy && paddr == `MFC_ADDR_REG)
				addr_reg <= pwdata[AW:0];
			if (wr_acc && !busy && paddr == `MFC_WDATA_REG)
				wdata_reg <= pwdata[15:0];
			if (wr_acc && paddr == `MFC_STATUS_REG && pwdata[`MFC_ST_DONE])
				op_done_reg <= 1'b0;
			case (state_reg)
				S_IDLE:
				begin
					if (ctrl_reg[`MFC_CTRL_RESET])
					begin
						state_reg <= S_RST; // [R16] [R22]
						cnt_reg <= RST_N[7:0];
					end
					else if (wr_acc && paddr == `MFC_CMD_REG &&
						!ctrl_reg[`MFC_CTRL_STANDBY])
					begin
						op_reg <= pwdata[1:0];
						if (pwdata[1:0] == `MFC_CMD_WRITE)
						begin
							state_reg <= S_WR; // [R5] [R12]
							cnt_reg <= WP_N[7:0];
						end
						else
						begin
							state_reg <= S_RD;
							cnt_reg <= ACC_N[7:0];
						end
					end
				end
				S_RD:
				begin
					if (cnt_reg == 8'h00)
					begin
						state_reg <= S_REC;
						cnt_reg <= WP_N[7:0];
					end
					else
						cnt_reg <= cnt_reg - 8'h01;
				end
				S_WR:
				begin
					if (cnt_reg == 8'h00)
					begin
						state_reg <= S_REC;
						cnt_reg <= WP_N[7:0];
					end
					else
						cnt_reg <= cnt_reg - 8'h01;
				end
				S_REC:
				begin
					if (cnt_reg == 8'h00)
					begin
						// taken only now: the chain needs three edges after the low strobe
						if (op_reg != `MFC_CMD_WRITE)
						begin
							rdata_reg <= word_mode ? dq_now : {8'h00, dq_now[7:0]};
							// two reads differing in bit six means still busy [R6]
							if (op_reg == `MFC_CMD_POLL)
								toggling_reg <= (rdata_reg[6] != dq_now[6]);
						end
						state_reg <= S_IDLE;
						op_done_reg <= 1'b1;
					end
					else
						cnt_reg <= cnt_reg - 8'h01;
				end
				S_RST:
				begin
					if (cnt_reg == 8'h00)
					begin
						state_reg <= S_IDLE;
						ctrl_reg[`MFC_CTRL_RESET] <= 1'b0;
					end
					else
						cnt_reg <= cnt_reg - 8'h01;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	// reads are never blocked on the done pin so an idle bank may be
	// read during another bank's operation; software owns that choice
	// [R1] [R2] [R23]
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flash_addr <= {AW{1'b0}};
			chip_sel_n <= 1'b1;
			out_en_n <= 1'b1;
			wr_en_n <= 1'b1;
			rst_n_pin <= 1'b0;
			width_sel_n <= 1'b1;
			protect_boost_pin <= 1'b0;
			dq_out <= 15'h0000;
			dq_oe <= 15'h0000;
			top_data_or_low_addr_out <= 1'b0;
			top_data_or_low_addr_oe <= 1'b0;
		end
		else if (pclken)
		begin
			flash_addr <= word_mode ? addr_reg[AW-1:0] : addr_reg[AW:1];
			// chip select low only inside a cycle, so standby holds [R18] [R14]
			chip_sel_n <= !(state_reg == S_RD || state_reg == S_WR);
			out_en_n <= (state_reg != S_RD);
			wr_en_n <= (state_reg != S_WR);
			rst_n_pin <= (state_reg != S_RST); // [R16]
			width_sel_n <= word_mode; // [R15]
			protect_boost_pin <= ctrl_reg[`MFC_CTRL_PROTECT]; // [R21]
			dq_out <= wdata_reg[14:0];
			// byte mode leaves bits fourteen to eight undriven [R20]
			dq_oe <= (state_reg == S_WR) ? (word_mode ? 15'h7FFF : 15'h00FF) : 15'h0000;
			// in byte mode the top pin carries the low address bit [R15]
			top_data_or_low_addr_out <= word_mode ? wdata_reg[15] : addr_reg[0];
			top_data_or_low_addr_oe <= word_mode ? (state_reg == S_WR) : 1'b1;
		end
	end

endmodule

// *** core/mfctl_defines.vh ***
// constants for the parallel nor flash host controller
// assumes a 40 MHz pclk and an apb master on the software side
`ifndef MFCTL_DEFINES_VH
`define MFCTL_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MFC_ADDR_REG 12'h000
`define MFC_WDATA_REG 12'h004
`define MFC_CMD_REG 12'h008
`define MFC_STATUS_REG 12'h00C
`define MFC_RDATA_REG 12'h010
`define MFC_CTRL_REG 12'h014

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MFC_CMD_READ 2'h0
`define MFC_CMD_WRITE 2'h1
`define MFC_CMD_POLL 2'h2
`define MFC_ST_BUSY 0
`define MFC_ST_DONE_N 1
`define MFC_ST_POLL 2
`define MFC_ST_TOG_A 3
`define MFC_ST_TOG_B 4
`define MFC_ST_LOCKED 5
`define MFC_ST_DONE 6
`define MFC_ST_TOGGLING 7
`define MFC_CTRL_WORD 0
`define MFC_CTRL_STANDBY 1
`define MFC_CTRL_PROTECT 2
`define MFC_CTRL_RESET 3
`define MFC_CTRL_RESET_VAL 4'h5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MFC_CLK_MHZ 40
`define MFC_T_ACC_NS 70
`define MFC_T_WP_NS 35
`define MFC_T_RST_NS 500
`define MFC_ACC_CYC ((`MFC_T_ACC_NS * `MFC_CLK_MHZ + 999) / 1000)
`define MFC_WP_CYC ((`MFC_T_WP_NS * `MFC_CLK_MHZ + 999) / 1000)
`define MFC_RST_CYC ((`MFC_T_RST_NS * `MFC_CLK_MHZ + 999) / 1000)

`endif

// *** verif/mfctl_host_monitor.sv ***
// flash pin checker for the nor flash host controller
// assumes bind onto mfctl_host, single pclk domain
`timescale 1ns/1ps
module mfctl_host_monitor (
	input wire pclk,
	input wire presetn,
	input wire chip_sel_n,
	input wire out_en_n,
	input wire wr_en_n,
	input wire width_sel_n,
	input wire [14:0] dq_oe,
	input wire top_data_or_low_addr_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_write_has_select: assert property (!wr_en_n |-> !chip_sel_n)
		else $error("write strobe without select");
	a_read_has_select: assert property (!out_en_n |-> !chip_sel_n)
		else $error("output enable without select");
	a_no_read_write: assert property (!(!out_en_n && !wr_en_n))
		else $error("read and write strobes together");
	a_write_pulse_len: assert property ($fell(wr_en_n) |-> !wr_en_n[*3] ##1 wr_en_n)
		else $error("write strobe length wrong");
	a_read_pulse_len: assert property ($fell(out_en_n) |-> !out_en_n[*4] ##1 out_en_n)
		else $error("read strobe length wrong");
	a_write_drives_bus: assert property (!wr_en_n && width_sel_n |-> dq_oe == 15'h7FFF)
		else $error("data not driven in write");
	a_byte_floats_high: assert property (!width_sel_n |-> dq_oe[14:8] == 7'h00)
		else $error("upper data driven in byte mode");
	a_byte_top_addr: assert property (!width_sel_n |-> top_data_or_low_addr_oe)
		else $error("top pin not driven in byte mode");
endmodule

bind mfctl_host mfctl_host_monitor mon_u (
	.pclk(pclk),
	.presetn(presetn),
	.chip_sel_n(chip_sel_n),
	.out_en_n(out_en_n),
	.wr_en_n(wr_en_n),
	.width_sel_n(width_sel_n),
	.dq_oe(dq_oe),
	.top_data_or_low_addr_oe(top_data_or_low_addr_oe)
);

// *** verif/mfctl_flash_model.sv ***
// behavioural clockless flash device with a small array
// assumes the bench resolves the shared data pins from both enables
`timescale 1ns/1ps
module mfctl_flash_model #(
	parameter BUSY_NS = 2000
)(
	input wire [20:0] addr,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire rst_n,
	input wire byte_n,
	input wire wp_n,
	input wire [14:0] dq_w,
	input wire dq15_w,
	output wire [14:0] dq_r,
	output wire dq15_r,
	output wire rdy_n
);
	reg [15:0] mem [0:15];
	reg [15:0] lv = 16'h0000;
	reg [15:0] wd;
	reg [3:0] wa;
	reg pend = 1'b0;
	reg busy_reg = 1'b0;
	integer j;
	// the part arrives erased
	initial
		for (j = 0; j < 16; j = j + 1)
			mem[j] = 16'hFFFF;
	wire rd = !ce_n && !oe_n && rst_n;
	wire [15:0] rv = mem[addr[3:0]];
	// released pins show the inverse of the last value so stale data never matches
	// byte mode: the top pin picks the byte, pins fourteen to eight float
	wire [7:0] rb = dq15_w ? rv[15:8] : rv[7:0];
	assign dq_r = rd ? (byte_n ? rv[14:0] : {~lv[14:8], rb}) : ~lv[14:0];
	assign dq15_r = (rd && byte_n) ? rv[15] : ~lv[15];
	assign rdy_n = !busy_reg;
	always @*
		if (rd)
			lv = rv;
	// capture while both strobes are low, commit when either rises
	always @(ce_n or we_n or addr or dq_w or dq15_w or rst_n)
	begin
		if (!ce_n && !we_n && rst_n)
		begin
			wa = addr[3:0];
			wd = {dq15_w, dq_w};
			pend = 1'b1;
		end
		else if (pend)
		begin
			pend = 1'b0;
			// outer sectors refuse programming while the protect pin is low
			if (!busy_reg && rst_n && (wp_n || (wa != 4'h0 && wa != 4'hF)))
			begin
				mem[wa] = wd;
				busy_reg = 1'b1;
			end
		end
	end
	always @(posedge busy_reg)
		#BUSY_NS busy_reg = 1'b0;
	always @(negedge rst_n)
		busy_reg = 1'b0;
endmodule

// *** verif/mfctl_tb.sv ***
// self-checking bench for the flash host controller over apb
// assumes the flash model answers on the pins
`timescale 1ns/1ps
`include "mfctl_defines.vh"
module testbench;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h00000000;
	reg [31:0] rd_val;
	integer err_count = 0;
	integer check_count = 0;
	integer i;
	wire [31:0] prdata;
	wire pready, pslverr, cs_n, oe_n, we_n, frst_n, byte_n, prot;
	wire [20:0] fa;
	wire [14:0] dq_in, dq_out, dq_oe, fl_dq;
	wire top_in, top_out, top_oe, fl_top, rdy_n;
	always #12.5 pclk = ~pclk;
	assign dq_in = (dq_oe & dq_out) | (~dq_oe & fl_dq);
	assign top_in = top_oe ? top_out : fl_top;
	mfctl_host dut_u (.pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(fa),
		.chip_sel_n(cs_n), .out_en_n(oe_n), .wr_en_n(we_n), .rst_n_pin(frst_n),
		.width_sel_n(byte_n), .protect_boost_pin(prot), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .top_data_or_low_addr_in(top_in), .top_data_or_low_addr_out(top_out),
		.top_data_or_low_addr_oe(top_oe), .done_flag_n(rdy_n));
	mfctl_flash_model mdl_u (.addr(fa), .ce_n(cs_n), .oe_n(oe_n), .we_n(we_n),
		.rst_n(frst_n), .byte_n(byte_n), .wp_n(prot), .dq_w(dq_out), .dq15_w(top_out),
		.dq_r(fl_dq), .dq15_r(fl_top), .rdy_n(rdy_n));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task end_sim;
	begin
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
	begin
		check_count = check_count + 1;
		if (g !== e)
		begin
			err_count = err_count + 1;
			$display("mismatch %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task xfer(input w, input [11:0] a, input [31:0] d);
		integer n;
	begin
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n = n + 1;
		end
		if (n == 20)
		begin
			chk("pready", 1, 0);
			end_sim;
		end
		rd_val = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	// polls status for a bit value; a hang counts as a mismatch and ends the run
	task wait_st(input integer b, input v, input integer lim);
		integer k;
	begin
		k = 0;
		xfer(0, `MFC_STATUS_REG, 0);
		while (rd_val[b] !== v && k < lim)
		begin
			xfer(0, `MFC_STATUS_REG, 0);
			k = k + 1;
		end
		if (k == lim)
		begin
			chk("wait", 0, 1);
			end_sim;
		end
	end
	endtask
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		xfer(0, `MFC_CTRL_REG, 0);
		chk("ctrl", `MFC_CTRL_RESET_VAL, rd_val);
		chk("prot", 1, prot);
		for (i = 0; i < 2; i = i + 1)
		begin
			xfer(1, `MFC_ADDR_REG, 3 + i);
			xfer(1, `MFC_WDATA_REG, 16'hA5C3 ^ i);
			xfer(1, `MFC_CMD_REG, `MFC_CMD_WRITE);
			// lands while the write cycle still runs, so it must be refused
			xfer(1, `MFC_ADDR_REG, 9);
			wait_st(`MFC_ST_DONE_N, 0, 30);
			if (i == 1)
			begin
				// read another location while the program is still running
				xfer(1, `MFC_ADDR_REG, 3);
				xfer(1, `MFC_STATUS_REG, 32'h40);
				xfer(1, `MFC_CMD_REG, `MFC_CMD_READ);
				wait_st(`MFC_ST_DONE, 1, 30);
				chk("ovl_busy", 0, rd_val[`MFC_ST_DONE_N]);
				xfer(0, `MFC_RDATA_REG, 0);
				chk("ovl_data", 32'h0000A5C3, rd_val);
			end
			wait_st(`MFC_ST_BUSY, 0, 200);
			chk("opdone", 1, rd_val[`MFC_ST_DONE]);
		end
		xfer(0, `MFC_ADDR_REG, 0);
		chk("addr", 3, rd_val);
		for (i = 0; i < 2; i = i + 1)
		begin
			xfer(1, `MFC_ADDR_REG, 3 + i);
			xfer(1, `MFC_CMD_REG, `MFC_CMD_READ);
			wait_st(`MFC_ST_BUSY, 0, 30);
			xfer(0, `MFC_RDATA_REG, 0);
			chk("rdata", 16'hA5C3 ^ i, rd_val[15:0]);
		end
		// byte mode: address bit zero on the top pin picks the high byte
		xfer(1, `MFC_CTRL_REG, 32'h4);
		xfer(1, `MFC_ADDR_REG, 7);
		xfer(1, `MFC_CMD_REG, `MFC_CMD_READ);
		wait_st(`MFC_ST_BUSY, 0, 30);
		xfer(0, `MFC_RDATA_REG, 0);
		chk("bytedata", 32'h000000A5, rd_val);
		xfer(1, `MFC_CTRL_REG, 32'h1);
		xfer(0, 12'h020, 0);
		chk("unmapped", 0, rd_val);
		chk("slverr", 0, pslverr);
		chk("prot", 0, prot);
		// with the protect pin low an outer sector keeps its erased content
		xfer(1, `MFC_ADDR_REG, 0);
		xfer(1, `MFC_WDATA_REG, 32'h1234);
		xfer(1, `MFC_CMD_REG, `MFC_CMD_WRITE);
		wait_st(`MFC_ST_BUSY, 0, 30);
		xfer(1, `MFC_CMD_REG, `MFC_CMD_READ);
		wait_st(`MFC_ST_BUSY, 0, 30);
		xfer(0, `MFC_RDATA_REG, 0);
		chk("guarded", 32'h0000FFFF, rd_val);
		xfer(1, `MFC_CTRL_REG, 32'h5);
		xfer(1, `MFC_ADDR_REG, 7);
		xfer(1, `MFC_CMD_REG, `MFC_CMD_WRITE);
		wait_st(`MFC_ST_DONE_N, 0, 30);
		// a reset pulse in mid-program must end the busy phase early
		xfer(1, `MFC_CTRL_REG, 32'hD);
		@(posedge pclk);
		@(posedge pclk);
		@(posedge pclk);
		chk("rstpin", 0, frst_n);
		wait_st(`MFC_ST_DONE_N, 1, 14);
		wait_st(`MFC_ST_BUSY, 0, 30);
		@(posedge pclk);
		chk("rstpin", 1, frst_n);
		xfer(0, `MFC_CTRL_REG, 0);
		chk("ctrl", 32'h5, rd_val);
		end_sim;
	end
endmodule
